// file: core/mode_cfg_pkg.sv
// Package with register map, field positions, reset values and mode codes
package mode_cfg_pkg;
  // Overview of operation
  // - Mode pins set operating mode; mode 1 is expanded, normal addressing, ROM off.
  // - Modes 2 and 3 keep ROM on; mode 2 advanced, mode 3 normal addressing.
  // - Modes 2 and 3 start single-chip; expansion only after expansion bit written 1.
  // - System control bit 2 picks interrupt edge: 0 falling, 1 rising; resets 0.
  // - System control bit 1 at 0 maps top windows to timer registers; resets 0.
  // - System control bit 1 at 1 maps windows to host and keyboard registers.
  // - System control bit 0 enables on-chip RAM; set to 1 at reset release.
  // - Wait control bit 5 selects width: 0 sixteen bit, 1 eight bit; resets 1.
  // - Wait control bit 4: 0 two-state no wait, 1 three-state waits; resets 1.
  // - Bits 3:2 pick wait mode in three-state: program, none, pin, pin auto.
  // - Internal accesses keep fixed width and states regardless of wait control.
  localparam logic [11:0] mode_ctrl_addr   = 12'h000;
  localparam logic [11:0] sys_ctrl_addr    = 12'h004;
  localparam logic [11:0] wait_ctrl_addr   = 12'h008;
  localparam logic [11:0] status_addr      = 12'h00C;
  localparam int          exp_bit          = 7;
  localparam int          nmi_edge_bit     = 2;
  localparam int          win_sel_bit      = 1;
  localparam int          ram_en_bit       = 0;
  localparam int          bus_width_bit    = 5;
  localparam int          state_cnt_bit    = 4;
  localparam int          wait_mode_lo     = 2;
  localparam logic [7:0]  sys_ctrl_reset   = 8'h01;
  localparam logic [7:0]  wait_ctrl_reset  = 8'h30;
  localparam logic [7:0]  sys_ctrl_mask    = 8'h07;
  localparam logic [7:0]  wait_ctrl_mask   = 8'h3F;
  localparam logic [1:0]  int_states       = 2'h2;
  localparam logic [1:0]  ext_states_short = 2'h2;
  localparam logic [1:0]  ext_states_long  = 2'h3;

  typedef enum logic [1:0] {
    wait_program  = 2'b00,
    wait_none     = 2'b01,
    wait_pin      = 2'b10,
    wait_pin_auto = 2'b11
  } wait_mode_e;

  typedef enum logic [1:0] {
    mode_bad = 2'b00,
    mode_one = 2'b01,
    mode_two = 2'b10,
    mode_three = 2'b11
  } op_mode_e;

  typedef struct packed {
    logic       expanded;
    logic       rom_enable;
    logic       advanced_addr;
    logic       nmi_rising;
    logic       host_window;
    logic       ram_enable;
    logic       ext_bus_8bit;
    logic [1:0] ext_states;
    logic       ext_wait_allowed;
    wait_mode_e ext_wait_mode;
  } sys_cfg_s;
endpackage

// file: core/mode_decode.sv
// Decoder from mode pins and expansion bit to operating attributes
`timescale 1ns/1ps
module mode_decode
  import mode_cfg_pkg::*;
(
  input  wire logic [1:0] pins,
  input  wire logic       expand,
  output logic            expanded,
  output logic            rom_enable,
  output logic            advanced_addr,
  output logic            mode_invalid
);
  always_comb begin
    expanded      = 1'b0;
    rom_enable    = 1'b0;
    advanced_addr = 1'b0;
    mode_invalid  = 1'b0;
    case (pins)
      mode_one: begin
        expanded = 1'b1;
      end
      mode_two: begin
        rom_enable    = 1'b1;
        advanced_addr = 1'b1;
        expanded      = expand;
      end
      mode_three: begin
        rom_enable = 1'b1;
        expanded   = expand;
      end
      default: begin
        mode_invalid = 1'b1;
      end
    endcase
  end
endmodule

// file: core/mode_select_bus_wait_config.sv
// Mode selection, system control and external wait control register bank
`timescale 1ns/1ps
module mode_select_bus_wait_config
  import mode_cfg_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        nrst,
  input  wire logic        mode_select_pin_high,
  input  wire logic        mode_select_pin_low,
  input  wire logic        ext_access,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  output sys_cfg_s         cfg,
  output logic             mode_invalid,
  output logic [1:0]       access_width_16,
  output logic [1:0]       access_states
);
  logic       expansion_enable_bit;
  logic [7:0] system_control_register;
  logic [7:0] external_wait_control_register;
  logic       next_expansion_enable_bit;
  logic [7:0] next_system_control_register;
  logic [7:0] next_external_wait_control_register;
  logic [31:0] next_prdata;
  logic       next_pready;
  logic       next_pslverr;
  sys_cfg_s   next_cfg;
  logic       next_mode_invalid;
  logic [1:0] next_access_width_16;
  logic [1:0] next_access_states;
  logic       dec_expanded;
  logic       dec_rom;
  logic       dec_adv;
  logic       dec_bad;
  logic       setup;
  logic       wr;
  logic       mapped;

  mode_decode u_dec (
    .pins          ({mode_select_pin_high, mode_select_pin_low}),
    .expand        (expansion_enable_bit),
    .expanded      (dec_expanded),
    .rom_enable    (dec_rom),
    .advanced_addr (dec_adv),
    .mode_invalid  (dec_bad)
  );

  assign setup  = psel && !penable;
  assign wr     = psel && penable && pready && pwrite && pstrb[0];
  assign mapped = (paddr == mode_ctrl_addr) || (paddr == sys_ctrl_addr) ||
                  (paddr == wait_ctrl_addr) || (paddr == status_addr);

  // Register writes and bus answer
  always_comb begin
    next_expansion_enable_bit           = expansion_enable_bit;
    next_system_control_register        = system_control_register;
    next_external_wait_control_register = external_wait_control_register;
    next_prdata  = prdata;
    next_pready  = 1'b0;
    next_pslverr = 1'b0;
    if (wr && paddr == mode_ctrl_addr) begin
      next_expansion_enable_bit = pwdata[exp_bit];
    end
    if (wr && paddr == sys_ctrl_addr) begin
      next_system_control_register = pwdata[7:0] & sys_ctrl_mask;
    end
    if (wr && paddr == wait_ctrl_addr) begin
      next_external_wait_control_register = pwdata[7:0] & wait_ctrl_mask;
    end
    if (setup) begin
      next_pready  = 1'b1;
      next_pslverr = !mapped;
      case (paddr)
        mode_ctrl_addr: next_prdata = {24'h000000, expansion_enable_bit, 7'h00};
        sys_ctrl_addr:  next_prdata = {24'h000000, system_control_register};
        wait_ctrl_addr: next_prdata = {24'h000000, external_wait_control_register};
        status_addr:    next_prdata = {28'h0000000, dec_bad, mode_select_pin_high,
                                       mode_select_pin_low, dec_expanded};
        default:        next_prdata = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      expansion_enable_bit           <= 1'b0;
      system_control_register        <= sys_ctrl_reset;
      external_wait_control_register <= wait_ctrl_reset;
      prdata  <= 32'h00000000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      expansion_enable_bit           <= next_expansion_enable_bit;
      system_control_register        <= next_system_control_register;
      external_wait_control_register <= next_external_wait_control_register;
      prdata  <= next_prdata;
      pready  <= next_pready;
      pslverr <= next_pslverr;
    end
  end

  // Bus answer checks
  a_ready_after_setup: assert property (
    @(posedge ref_clk) disable iff (!nrst)
    setup |=> pready
  ) else $error("No answer after setup");

  a_ready_one_pulse: assert property (
    @(posedge ref_clk) disable iff (!nrst)
    pready |=> !pready
  ) else $error("Ready held too long");

  a_error_unmapped: assert property (
    @(posedge ref_clk) disable iff (!nrst)
    setup && !mapped |=> pslverr
  ) else $error("Unmapped address not refused");

  a_error_mapped: assert property (
    @(posedge ref_clk) disable iff (!nrst)
    setup && mapped |=> !pslverr
  ) else $error("Mapped address refused");

  a_strobe_ignore: assert property (
    @(posedge ref_clk) disable iff (!nrst)
    psel && penable && pready && pwrite && !pstrb[0]
    |=> $stable(expansion_enable_bit) && $stable(system_control_register)
        && $stable(external_wait_control_register)
  ) else $error("Write without byte strobe landed");

  a_mode_read_back: assert property (
    @(posedge ref_clk) disable iff (!nrst)
    setup && paddr == mode_ctrl_addr
    |=> prdata == {24'h000000, $past(expansion_enable_bit), 7'h00}
  ) else $error("Mode control read wrong");

  a_sys_read_back: assert property (
    @(posedge ref_clk) disable iff (!nrst)
    setup && paddr == sys_ctrl_addr
    |=> prdata == {24'h000000, $past(system_control_register)}
  ) else $error("System control read wrong");

  a_wait_read_back: assert property (
    @(posedge ref_clk) disable iff (!nrst)
    setup && paddr == wait_ctrl_addr
    |=> prdata == {24'h000000, $past(external_wait_control_register)}
  ) else $error("Wait control read wrong");

  a_status_upper: assert property (
    @(posedge ref_clk) disable iff (!nrst)
    setup && paddr == status_addr |=> prdata[31:4] == 28'h0000000
  ) else $error("Status upper bits set");

  // Configuration outputs
  always_comb begin
    next_cfg.expanded         = dec_expanded;
    next_cfg.rom_enable       = dec_rom;
    next_cfg.advanced_addr    = dec_adv;
    next_cfg.nmi_rising       = system_control_register[nmi_edge_bit];
    next_cfg.host_window      = system_control_register[win_sel_bit];
    next_cfg.ram_enable       = system_control_register[ram_en_bit];
    next_cfg.ext_bus_8bit     = external_wait_control_register[bus_width_bit];
    next_cfg.ext_wait_allowed = external_wait_control_register[state_cnt_bit];
    next_cfg.ext_states       = external_wait_control_register[state_cnt_bit] ?
                                ext_states_long : ext_states_short;
    next_cfg.ext_wait_mode    = external_wait_control_register[state_cnt_bit] ?
                                wait_mode_e'(external_wait_control_register[3:2]) :
                                wait_none;
    next_mode_invalid = dec_bad;
    if (ext_access) begin
      next_access_width_16 = external_wait_control_register[bus_width_bit] ? 2'h1 : 2'h2;
      next_access_states   = next_cfg.ext_states;
    end else begin
      next_access_width_16 = 2'h2;
      next_access_states   = int_states;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      cfg             <= '0;
      mode_invalid    <= 1'b0;
      access_width_16 <= 2'h0;
      access_states   <= 2'h0;
    end else begin
      cfg             <= next_cfg;
      mode_invalid    <= next_mode_invalid;
      access_width_16 <= next_access_width_16;
      access_states   <= next_access_states;
    end
  end

  // Reset value checks
  a_ram_reset_on: assert property (
    @(posedge ref_clk)
    $rose(nrst) |-> ##1 cfg.ram_enable
  ) else $error("RAM not enabled after reset");

  a_wait_reset_val: assert property (
    @(posedge ref_clk)
    $rose(nrst) |-> ##1 (cfg.ext_bus_8bit && cfg.ext_wait_allowed && !cfg.nmi_rising
    && !cfg.host_window)
  ) else $error("Bad control values after reset");

  a_single_chip_start: assert property (
    @(posedge ref_clk)
    $rose(nrst) && mode_select_pin_high |-> ##1 !cfg.expanded
  ) else $error("Expanded straight after reset");

  // Mode checks
  a_mode_one_rom: assert property (
    @(posedge ref_clk) disable iff (!nrst)
    !mode_select_pin_high && mode_select_pin_low |=> cfg.expanded && !cfg.rom_enable
  ) else $error("Mode one attributes wrong");

  a_mode_two_adv: assert property (
    @(posedge ref_clk) disable iff (!nrst)
    mode_select_pin_high
    |=> cfg.rom_enable && cfg.advanced_addr == !$past(mode_select_pin_low)
  ) else $error("Mode two or three wrong");

  a_mode_valid_flag: assert property (
    @(posedge ref_clk) disable iff (!nrst)
    mode_select_pin_high || mode_select_pin_low |=> !mode_invalid
  ) else $error("Valid mode flagged invalid");

  a_expand_write: assert property (
    @(posedge ref_clk) disable iff (!nrst)
    wr && paddr == mode_ctrl_addr && pwdata[exp_bit] && mode_select_pin_high
    |-> ##2 cfg.expanded
  ) else $error("Expansion not entered");

  a_expand_clear: assert property (
    @(posedge ref_clk) disable iff (!nrst)
    wr && paddr == mode_ctrl_addr && !pwdata[exp_bit] && mode_select_pin_high
    |-> ##2 !cfg.expanded
  ) else $error("Expansion not left");

  // System control checks
  a_sys_write_use: assert property (
    @(posedge ref_clk) disable iff (!nrst)
    wr && paddr == sys_ctrl_addr
    |-> ##2 (cfg.nmi_rising == $past(pwdata[nmi_edge_bit], 2)
    && cfg.host_window == $past(pwdata[win_sel_bit], 2))
  ) else $error("System bits not applied");

  a_timer_window: assert property (
    @(posedge ref_clk) disable iff (!nrst)
    wr && paddr == sys_ctrl_addr && !pwdata[win_sel_bit] |-> ##2 !cfg.host_window
  ) else $error("Timer window not selected");

  a_host_window_on: assert property (
    @(posedge ref_clk) disable iff (!nrst)
    wr && paddr == sys_ctrl_addr && pwdata[win_sel_bit] |-> ##2 cfg.host_window
  ) else $error("Host window not selected");

  a_ram_write: assert property (
    @(posedge ref_clk) disable iff (!nrst)
    wr && paddr == sys_ctrl_addr
    |-> ##2 cfg.ram_enable == $past(pwdata[ram_en_bit], 2)
  ) else $error("RAM enable not applied");

  // Wait control checks
  a_reserved_zero: assert property (
    @(posedge ref_clk) disable iff (!nrst)
    external_wait_control_register[7:6] == 2'b00
  ) else $error("Reserved bits set");

  a_wait_write: assert property (
    @(posedge ref_clk) disable iff (!nrst)
    wr && paddr == wait_ctrl_addr
    |-> ##2 cfg.ext_bus_8bit == $past(pwdata[bus_width_bit], 2)
  ) else $error("Bus width not applied");

  a_width_sel: assert property (
    @(posedge ref_clk) disable iff (!nrst)
    ext_access |=> access_width_16 ==
    ($past(external_wait_control_register[bus_width_bit]) ? 2'h1 : 2'h2)
  ) else $error("Width wrong");

  a_short_no_wait: assert property (
    @(posedge ref_clk) disable iff (!nrst)
    !external_wait_control_register[state_cnt_bit]
    |=> cfg.ext_states == ext_states_short && cfg.ext_wait_mode == wait_none
  ) else $error("Two-state waits");

  a_long_states: assert property (
    @(posedge ref_clk) disable iff (!nrst)
    external_wait_control_register[state_cnt_bit]
    |=> cfg.ext_states == ext_states_long && cfg.ext_wait_allowed
  ) else $error("Three-state access not set");

  a_ext_states_out: assert property (
    @(posedge ref_clk) disable iff (!nrst)
    ext_access |=> access_states == cfg.ext_states
  ) else $error("External states wrong");

  a_wait_mode_sel: assert property (
    @(posedge ref_clk) disable iff (!nrst)
    external_wait_control_register[state_cnt_bit]
    |=> cfg.ext_wait_mode == $past(external_wait_control_register[3:2])
  ) else $error("Wait mode wrong");

  a_internal_fixed: assert property (
    @(posedge ref_clk) disable iff (!nrst)
    !ext_access |=> access_states == int_states && access_width_16 == 2'h2
  ) else $error("Internal access altered");
endmodule

// file: sim/ext_bus_model.sv
// Expansion bus stand-in marking which CPU accesses go off chip
`timescale 1ns/1ps
module ext_bus_model (
  input  wire logic ref_clk,
  input  wire logic nrst,
  output logic      ext_access
);
  logic [3:0] run;
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      run        <= 4'h0;
      ext_access <= 1'b0;
    end else begin
      run        <= run + 4'h1;
      ext_access <= run[2] ^ run[0];
    end
  end
endmodule

// file: sim/mode_select_bus_wait_config_test.sv
// Self-checking bench for the mode and wait control register bank
`timescale 1ns/1ps
module mode_select_bus_wait_config_test;
  import mode_cfg_pkg::*;
  logic        ref_clk, nrst, pin_hi, pin_lo, psel, penable, pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdata, seed;
  logic [3:0]  pstrb;
  logic        pready, pslverr, ext_access, mode_invalid, err, ext_prev;
  logic [1:0]  access_width_16, access_states;
  sys_cfg_s    cfg;
  int          fail_count, check_count;

  mode_select_bus_wait_config mode_select_bus_wait_config_inst (
    .ref_clk(ref_clk), .nrst(nrst), .mode_select_pin_high(pin_hi),
    .mode_select_pin_low(pin_lo), .ext_access(ext_access), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cfg(cfg), .mode_invalid(mode_invalid), .access_width_16(access_width_16),
    .access_states(access_states));
  ext_bus_model ext_bus_model_inst (.ref_clk(ref_clk), .nrst(nrst), .ext_access(ext_access));

  task automatic stop_test;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask

  function automatic logic [31:0] next_rand(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  function automatic logic [2:0] exp_mode(input logic [1:0] p, input logic e);
    return (p == 2'h1) ? 3'b100 : {e, 1'b1, p == 2'h2};
  endfunction

  function automatic logic [5:0] wait_cfg(input logic [5:0] w);
    return {w[5], (w[4] ? ext_states_long : ext_states_short), w[4], (w[4] ? w[3:2] : wait_none)};
  endfunction

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     input logic [3:0] st);
    int n;
    @(posedge ref_clk);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    pstrb   <= st;
    @(posedge ref_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      fail_count++;
      stop_test();
    end
    rdata = prdata;
    err   = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end

  initial begin
    {nrst, pin_hi, pin_lo, psel, penable, pwrite} = 6'b001000;
    {paddr, pwdata, pstrb} = '0;
    fail_count = 0;
    check_count = 0;
    seed = 32'hE9119F0A;
    for (int m = 1; m < 4; m++) begin
      @(posedge ref_clk);
      nrst <= 1'b0;
      {pin_hi, pin_lo} <= 2'(m);
      repeat (20) @(posedge ref_clk);
      nrst <= 1'b1;
      repeat (2) @(posedge ref_clk);
      check("mode", {cfg.expanded, cfg.rom_enable, cfg.advanced_addr}, exp_mode(2'(m), 0));
      check("invalid", mode_invalid, 0);
      apb(0, sys_ctrl_addr, 0, 0);
      check("sys reset", rdata, 32'h1);
      apb(0, wait_ctrl_addr, 0, 0);
      check("wait reset", rdata, 32'h30);
      apb(1, mode_ctrl_addr, 32'h80, 4'hF);
      repeat (2) @(posedge ref_clk);
      check("expand", {cfg.expanded, cfg.rom_enable, cfg.advanced_addr}, exp_mode(2'(m), 1));
      apb(0, status_addr, 0, 0);
      check("status", rdata, {28'h0, 1'b0, 2'(m), 1'b1});
      apb(1, mode_ctrl_addr, 32'h00000000, 4'hF);
      repeat (2) @(posedge ref_clk);
      check("leave", {cfg.expanded, cfg.rom_enable, cfg.advanced_addr}, exp_mode(2'(m), 0));
      apb(1, 12'h010, 32'hFF, 4'hF);
      check("slverr", err, 1);
      repeat (6) begin
        seed = next_rand(seed);
        apb(1, sys_ctrl_addr, seed, 4'hF);
        apb(1, wait_ctrl_addr, {24'h000000, 2'b00, seed[13:8]}, 4'hF);
        repeat (2) @(posedge ref_clk);
        check("sys cfg", {cfg.nmi_rising, cfg.host_window, cfg.ram_enable}, seed[2:0]);
        check("wait cfg", {cfg.ext_bus_8bit, cfg.ext_states, cfg.ext_wait_allowed,
                           cfg.ext_wait_mode}, wait_cfg(seed[13:8]));
        apb(1, sys_ctrl_addr, ~seed, 4'hE);
        apb(0, sys_ctrl_addr, 0, 0);
        check("sys read", rdata, {29'h0, seed[2:0]});
        apb(0, wait_ctrl_addr, 0, 0);
        check("wait read", rdata, {26'h0, seed[13:8]});
        for (int k = 0; k < 12; k++) begin
          @(posedge ref_clk);
          if (k > 0) begin
            check("states", access_states,
                  ext_prev ? (seed[12] ? ext_states_long : ext_states_short) : int_states);
            if (ext_prev)
              check("width", access_width_16, seed[13] ? 2'h1 : 2'h2);
          end
          ext_prev = ext_access;
        end
      end
    end
    stop_test();
  end
endmodule
